/* File: rtl/nvs_pkg.sv */
// constants and types for the nonvolatile command-list sequencer
// Overview of operation
// - Command bit 7 clear means data transfer
// - Low seven bits give byte count minus one
// - Next two bytes: start address, high first
// - Bit 7 set: apply or end opcode
// - Apply opcode acts like writing update register
// - End opcode stops walk, ends transfer
// - List lives in segment; uses listed spans
// - Reset list moves everything, then applies
// - Apply copies buffers next edge, self-clears
// - Pending flag high while transfer runs
// - Save trigger self-clears when save finishes
package nvs_pkg;
	localparam logic [15:0] SEG_BASE      = 16'h0a00;
	localparam logic [15:0] SEG_LAST      = 16'h0aff;
	localparam logic [15:0] UPDATE_ADDR   = 16'h0232;
	localparam logic [15:0] STATUS_ADDR   = 16'h0b00;
	localparam logic [15:0] SAVE_ADDR     = 16'h0b03;
	localparam int          OP_BIT        = 7;
	localparam int          TRIG_BIT      = 0;
	localparam logic [7:0]  OP_APPLY      = 8'h80;
	localparam logic [7:0]  OP_END        = 8'hff;
	localparam int          SEG_DEPTH     = 256;
	// default list: DEF_CHUNKS entries of 128 bytes from address zero
	localparam logic [7:0]  DEF_CMD       = 8'h7f;
	localparam int          DEF_CHUNKS    = 5;
	localparam int          DEF_ENTRY_LEN = 3;
	localparam int          DEF_SPAN      = 128;

	typedef enum logic [6:0]
	{
		ST_IDLE    = 7'b0000001,
		ST_CMD     = 7'b0000010,
		ST_ADDR_HI = 7'b0000100,
		ST_ADDR_LO = 7'b0001000,
		ST_MOVE    = 7'b0010000,
		ST_WAIT    = 7'b0100000,
		ST_APPLY   = 7'b1000000
	} nvs_state_t;

	typedef struct packed
	{
		logic        to_nv;
		logic [15:0] reg_addr;
		logic [15:0] nv_addr;
	} nvs_xfer_t;

	function automatic logic [7:0] default_seg_byte(input int idx);
		int          entry;
		logic [15:0] start;
		entry = idx / DEF_ENTRY_LEN;
		start = 16'(entry * DEF_SPAN);
		if (entry < DEF_CHUNKS)
		begin
			case (idx % DEF_ENTRY_LEN)
				0:       return DEF_CMD;
				1:       return start[15:8];
				default: return start[7:0];
			endcase
		end
		else if (idx == DEF_CHUNKS * DEF_ENTRY_LEN)
			return OP_APPLY;
		else
			return OP_END;
	endfunction : default_seg_byte
endpackage : nvs_pkg

/* File: rtl/nvs_sequencer.sv */
// command-list walker moving register spans to and from nonvolatile memory
`timescale 1ns/100ps
`default_nettype none
module nvs_sequencer
(
	input  wire logic               CLK,
	input  wire logic               RST,
	input  wire logic               REG_WE,
	input  wire logic [15:0]        REG_ADDR,
	input  wire logic [7:0]         REG_WDATA,
	output logic      [7:0]         REG_RDATA,
	input  wire logic               LOAD_START,
	output nvs_pkg::nvs_xfer_t      XFER,
	output logic                    XFER_REQ,
	input  wire logic               XFER_DONE,
	output logic                    UPDATE,
	output logic                    PENDING
);
	import nvs_pkg::*;

	logic [7:0]  seg [SEG_DEPTH];
	nvs_state_t  state;
	nvs_state_t  next_state;
	logic [8:0]  ptr;
	logic [8:0]  next_ptr;
	logic [6:0]  remain;
	logic [6:0]  next_remain;
	logic        save_bit;
	logic        finish;
	logic [7:0]  cur;
	logic        in_seg;
	nvs_xfer_t   next_xfer;

	assign cur    = seg[ptr[7:0]];
	assign in_seg = (REG_ADDR >= SEG_BASE) && (REG_ADDR <= SEG_LAST);

	// segment storage, software writable
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			for (int i = 0; i < SEG_DEPTH; i++)
				seg[i] <= default_seg_byte(i);
		end
		else if (REG_WE && in_seg)
			seg[REG_ADDR[7:0]] <= REG_WDATA;
	end

	// save trigger: a new write in the finishing cycle wins over the clear
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			save_bit <= 1'b0;
		else if (REG_WE && REG_ADDR == SAVE_ADDR && REG_WDATA[TRIG_BIT])
			save_bit <= 1'b1;
		else if (finish && XFER.to_nv)
			save_bit <= 1'b0;
	end

	always_comb
	begin
		next_state  = state;
		next_ptr    = ptr;
		next_remain = remain;
		next_xfer   = XFER;
		finish      = 1'b0;
		unique case (state)
			ST_IDLE:
			begin
				next_ptr          = 9'h000;
				next_xfer.nv_addr = 16'h0000;
				if (save_bit)
				begin
					next_xfer.to_nv = 1'b1;
					next_state      = ST_CMD;
				end
				else if (LOAD_START)
				begin
					next_xfer.to_nv = 1'b0;
					next_state      = ST_CMD;
				end
			end
			ST_CMD:
			begin
				// running off the segment end acts as end of data
				if (ptr[8] || (cur[OP_BIT] && cur != OP_APPLY))
				begin
					finish     = 1'b1;
					next_state = ST_IDLE;
				end
				else if (!cur[OP_BIT])
				begin
					next_remain = cur[6:0];
					next_ptr    = ptr + 9'h001;
					next_state  = ST_ADDR_HI;
				end
				else
				begin
					next_ptr   = ptr + 9'h001;
					next_state = ST_APPLY;
				end
			end
			ST_ADDR_HI:
			begin
				next_xfer.reg_addr[15:8] = cur;
				next_ptr                 = ptr + 9'h001;
				next_state               = ptr[8] ? ST_CMD : ST_ADDR_LO;
			end
			ST_ADDR_LO:
			begin
				next_xfer.reg_addr[7:0] = cur;
				next_ptr                = ptr + 9'h001;
				next_state              = ptr[8] ? ST_CMD : ST_MOVE;
			end
			ST_MOVE:
				next_state = ST_WAIT;
			ST_WAIT:
			begin
				if (XFER_DONE)
				begin
					next_xfer.nv_addr = XFER.nv_addr + 16'h0001;
					if (remain == 7'h00)
						next_state = ST_CMD;
					else
					begin
						next_remain        = remain - 7'h01;
						next_xfer.reg_addr = XFER.reg_addr + 16'h0001;
						next_state         = ST_MOVE;
					end
				end
			end
			ST_APPLY:
				next_state = ST_CMD;
		endcase
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state  <= ST_IDLE;
			ptr    <= 9'h000;
			remain <= 7'h00;
			XFER   <= '0;
		end
		else
		begin
			state  <= next_state;
			ptr    <= next_ptr;
			remain <= next_remain;
			XFER   <= next_xfer;
		end
	end

	// one request per byte; the partner answers with XFER_DONE
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			XFER_REQ <= 1'b0;
		else
			XFER_REQ <= (next_state == ST_MOVE);
	end

	// apply pulse from opcode or from a software write; stays high while that write is held
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			UPDATE <= 1'b0;
		else
			UPDATE <= (next_state == ST_APPLY) ||
				(REG_WE && REG_ADDR == UPDATE_ADDR && REG_WDATA[TRIG_BIT]);
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			PENDING <= 1'b0;
		else
			PENDING <= (next_state != ST_IDLE);
	end

	// read data one cycle after the address; update bit always reads zero
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			REG_RDATA <= 8'h00;
		else if (in_seg)
			REG_RDATA <= seg[REG_ADDR[7:0]];
		else if (REG_ADDR == STATUS_ADDR)
			REG_RDATA <= {7'h00, PENDING};
		else if (REG_ADDR == SAVE_ADDR)
			REG_RDATA <= {7'h00, save_bit};
		else
			REG_RDATA <= 8'h00;
	end

	data_cmd_a: assert property (@(posedge CLK) disable iff (RST)
		state == ST_CMD && !ptr[8] && !cur[OP_BIT] |=> state == ST_ADDR_HI)
		else $error("data command not decoded");
	count_load_a: assert property (@(posedge CLK) disable iff (RST)
		state == ST_CMD && !ptr[8] && !cur[OP_BIT] |=> remain == $past(cur[6:0]))
		else $error("byte count wrong");
	addr_order_a: assert property (@(posedge CLK) disable iff (RST)
		state == ST_ADDR_HI && !ptr[8] ##1 state == ST_ADDR_LO
		|=> XFER.reg_addr == {$past(cur, 2), $past(cur)})
		else $error("start address wrong");
	op_apply_a: assert property (@(posedge CLK) disable iff (RST)
		state == ST_CMD && !ptr[8] && cur == OP_APPLY |=> UPDATE ##1 state == ST_CMD)
		else $error("apply opcode missed");
	op_end_a: assert property (@(posedge CLK) disable iff (RST)
		state == ST_CMD && cur[OP_BIT] && cur != OP_APPLY |=> state == ST_IDLE && !PENDING)
		else $error("end opcode did not stop walk");
	upd_write_a: assert property (@(posedge CLK) disable iff (RST)
		REG_WE && REG_ADDR == UPDATE_ADDR && REG_WDATA[TRIG_BIT] |=> UPDATE)
		else $error("update write lost");
	pending_flag_a: assert property (@(posedge CLK) disable iff (RST)
		PENDING == (state != ST_IDLE))
		else $error("pending flag wrong");
	save_clear_a: assert property (@(posedge CLK) disable iff (RST)
		finish && XFER.to_nv && !(REG_WE && REG_ADDR == SAVE_ADDR) |=> !save_bit)
		else $error("save trigger not cleared");
	walk_step_a: assert property (@(posedge CLK) disable iff (RST)
		state == ST_ADDR_HI |=> ptr == $past(ptr) + 9'h001)
		else $error("walk did not advance");
	seg_write_a: assert property (@(posedge CLK) disable iff (RST)
		REG_WE && in_seg |=> seg[$past(REG_ADDR[7:0])] == $past(REG_WDATA))
		else $error("segment write lost");
endmodule : nvs_sequencer
`default_nettype wire

/* File: bench/nvs_nv_model.sv */
// nonvolatile memory stand-in answering byte transfer requests
`timescale 1ns/100ps
`default_nettype none
module nvs_nv_model
(
	input  wire logic               CLK,
	input  wire logic               RST,
	input  wire nvs_pkg::nvs_xfer_t XFER,
	input  wire logic               XFER_REQ,
	input  wire logic [3:0]         DLY,
	output var  logic               XFER_DONE,
	output var  int                 cnt,
	output var  nvs_pkg::nvs_xfer_t last
);
	int left;
	// one byte at a time; DLY sets how slow the array answers
	always @(negedge CLK or posedge RST)
		if (RST)
		begin
			XFER_DONE <= 1'b0;
			cnt <= 0;
			left <= 0;
		end
		else
		begin
			XFER_DONE <= left == 1;
			if (left > 0)
				left <= left - 1;
			else if (XFER_REQ === 1'b1)
			begin
				last <= XFER;
				cnt <= cnt + 1;
				left <= DLY;
			end
		end
endmodule : nvs_nv_model
`default_nettype wire

/* File: bench/nvs_sequencer_bench.sv */
// self-checking bench for the command-list sequencer
`timescale 1ns/100ps
`default_nettype none
module nvs_sequencer_bench;
	import nvs_pkg::*;
	logic        clk, rst, we, load, req, done, upd, pend;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, rv;
	logic [3:0]  dly;
	nvs_xfer_t   xfer, last;
	int          cnt, upd_cnt, error_cnt, n_checks, cyc, c0, u0;
	// 100 cycles of 100 ns give the ten microsecond gap between walks
	localparam int GAP_CYCLES = 100;

	nvs_sequencer i_dut (.CLK(clk), .RST(rst), .REG_WE(we), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .LOAD_START(load), .XFER(xfer),
		.XFER_REQ(req), .XFER_DONE(done), .UPDATE(upd), .PENDING(pend));
	nvs_nv_model i_nv (.CLK(clk), .RST(rst), .XFER(xfer), .XFER_REQ(req),
		.DLY(dly), .XFER_DONE(done), .cnt(cnt), .last(last));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// timeout ceiling well above the longest walk
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (upd === 1'b1)
			upd_cnt <= upd_cnt + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task check(input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		we = 1'b0;
	endtask : wr

	task rdb(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		d = rdata;
	endtask : rdb

	// runs one save or load walk to its end and checks the status bits
	task walk(input logic save, input logic long_walk);
		int i;
		repeat (GAP_CYCLES) @(negedge clk);
		c0 = cnt;
		u0 = upd_cnt;
		if (save)
			wr(SAVE_ADDR, 8'h01);
		else
		begin
			@(negedge clk);
			load = 1'b1;
			@(negedge clk);
			load = 1'b0;
		end
		for (i = 0; i < 10 && pend !== 1'b1; i++)
			@(negedge clk);
		check(pend, 1'b1);
		if (long_walk)
		begin
			rdb(STATUS_ADDR, rv);
			check(rv, 8'h01);
		end
		for (i = 0; i < 6000 && pend !== 1'b0; i++)
			@(negedge clk);
		rdb(STATUS_ADDR, rv);
		check(rv, 8'h00);
		rdb(SAVE_ADDR, rv);
		check(rv, 8'h00);
	endtask : walk

	task s_default;
		int i;
		for (i = 0; i < 16; i++)
		begin
			rdb(SEG_BASE + 16'(i), rv);
			if (i == 15)
				check(rv, 8'h80);
			else
				check(rv, i % 3 == 0 ? 8'h7f : (i % 3 == 1 ? 8'(i / 3 / 2) : 8'(i / 3 % 2 * 128)));
		end
		rdb(SEG_LAST, rv);
		check(rv, 8'hff);
		walk(1'b0, 1'b1);
		check(cnt - c0, 640);
		check({last.to_nv, last.reg_addr, last.nv_addr}, {1'b0, 16'h027f, 16'd639});
		check(upd_cnt - u0, 1);
	endtask : s_default

	task s_custom;
		logic [7:0] lst [8];
		int i;
		lst = '{8'h01, 8'h12, 8'h34, 8'h80, 8'h00, 8'h00, 8'h05, 8'hff};
		for (i = 0; i < 8; i++)
			wr(SEG_BASE + 16'(i), lst[i]);
		wr(SEG_LAST, OP_END);
		rdb(SEG_BASE + 16'h0001, rv);
		check(rv, 8'h12);
		dly = 4'h4;
		walk(1'b1, 1'b1);
		check(cnt - c0, 3);
		check({last.to_nv, last.reg_addr, last.nv_addr}, {1'b1, 16'h0005, 16'd2});
		check(upd_cnt - u0, 1);
	endtask : s_custom

	task s_unknown;
		wr(SEG_BASE, 8'h81);
		walk(1'b0, 1'b0);
		check(cnt - c0, 0);
		check(upd_cnt - u0, 0);
	endtask : s_unknown

	task s_update;
		u0 = upd_cnt;
		wr(UPDATE_ADDR, 8'h01);
		repeat (3) @(negedge clk);
		check(upd_cnt - u0, 1);
		rdb(UPDATE_ADDR, rv);
		check(rv, 8'h00);
	endtask : s_update

	initial
	begin
		rst = 1'b1;
		we = 1'b0;
		load = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		dly = 4'h1;
		upd_cnt = 0;
		repeat (6) @(negedge clk);
		check({pend, upd, req}, 3'b000);
		rst = 1'b0;
		s_default();
		s_custom();
		s_unknown();
		s_update();
		tally_and_finish();
	end
endmodule : nvs_sequencer_bench
`default_nettype wire
